//--- sxp_pkg.sv
// Constants for the SFR decode and external RAM page block
package sxp_pkg;
    localparam logic [7:0] SXP_SFR_BASE      = 8'h80;
    localparam logic [7:0] SXP_PAGE_REG_ADDR = 8'haa;
    localparam logic [7:0] SXP_PAGE_REG_RST  = 8'h00;
    localparam int         SXP_PAGE_SEL_POS  = 0;
    localparam logic [2:0] SXP_BIT_ADDR_LOW  = 3'h0;
    localparam int         SXP_XRAM_AW       = 9;
endpackage

//--- sxp_sfr_decode.sv
// SFR space decode and external RAM page register
//
// Operation
// - Eight-bit external moves take the high address byte from page register.
// - Page register bits 7..1 read zero; writes to them are ignored.
// - Only the page select bit picks the 256-byte RAM page.
// - Direct accesses at 0x80..0xFF go to SFR space, not RAM.
// - Only SFRs ending in 0x0 or 0x8 accept bit operations.
// - Indirect accesses above 0x7F reach upper internal RAM.
// - Sixteen-bit pointer moves drop upper seven bits; RAM repeats.
`timescale 1ns/1ps
module sxp_sfr_decode
    import sxp_pkg::*;
#(
    // External RAM index width
    parameter int XRAM_AW = SXP_XRAM_AW
)
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Core data memory access
    input  wire logic                   mem_req,
    input  wire logic                   mem_direct,
    input  wire logic                   mem_bit_op,
    input  wire logic                   mem_wr,
    input  wire logic [7:0]             mem_addr,
    input  wire logic [7:0]             mem_wdata,
    input  wire logic [2:0]             mem_bit_pos,
    // External data move
    input  wire logic                   xmove_req,
    input  wire logic                   xmove_ptr16,
    input  wire logic [15:0]            xmove_addr,
    // Decode results, one cycle after request
    output logic                        sfr_sel,
    output logic                        iram_sel,
    output logic                        bit_ok,
    output logic                        page_reg_hit,
    output logic [7:0]                  sfr_rdata,
    output logic                        xram_en,
    output logic [XRAM_AW-1:0]          xram_index,
    output logic                        page_select_bit
);
    // Page register state
    logic                   page_r;
    logic                   page_nxt;

    // Access decode state
    logic                   sfr_sel_r;
    logic                   sfr_sel_nxt;
    logic                   iram_sel_r;
    logic                   iram_sel_nxt;
    logic                   bit_ok_r;
    logic                   bit_ok_nxt;
    logic                   hit_r;
    logic                   hit_nxt;
    logic [7:0]             rdata_r;
    logic [7:0]             rdata_nxt;

    // External move state
    logic                   xen_r;
    logic                   xen_nxt;
    logic [XRAM_AW-1:0]     xidx_r;
    logic [XRAM_AW-1:0]     xidx_nxt;

    // Terms shared by the groups
    logic                   in_sfr;
    logic                   in_iram;
    logic                   is_page;
    logic                   bit_addr;
    logic                   page_wr;
    logic [7:0]             cur_byte;
    logic [7:0]             bit_wdata;
    logic [XRAM_AW-1:0]     paged_idx;
    logic [XRAM_AW-1:0]     linear_idx;

    // Address space steering for the current access
    always_comb begin
        in_sfr  = 1'b0;
        in_iram = 1'b0;

        case ({mem_req, mem_direct})
            2'b11: begin
                in_sfr  = (mem_addr >= SXP_SFR_BASE);
                in_iram = (mem_addr < SXP_SFR_BASE);
            end
            2'b10: begin
                in_iram = 1'b1;
            end
            default: begin
                // No access this cycle
                in_sfr  = 1'b0;
                in_iram = 1'b0;
            end
        endcase
    end

    // Register match and bit-write merge
    always_comb begin
        bit_addr  = (mem_addr[2:0] == SXP_BIT_ADDR_LOW);
        is_page   = in_sfr && (mem_addr == SXP_PAGE_REG_ADDR);

        // bit ops on byte-only SFRs refused
        page_wr   = is_page && mem_wr && (!mem_bit_op || bit_addr);

        cur_byte  = {7'h00, page_r};
        // Old byte keeps the untouched bits
        bit_wdata = cur_byte;
        bit_wdata[mem_bit_pos] = mem_wdata[0];
    end

    // Both index forms every cycle; the request picks one
    always_comb begin
        // upper seven bits ignored, RAM repeats
        linear_idx = xmove_addr[XRAM_AW-1:0];
        paged_idx  = XRAM_AW'({page_r, xmove_addr[7:0]});
    end

    // Page register next value
    always_comb begin
        page_nxt = page_r;

        if (page_wr) begin
            if (mem_bit_op) begin
                page_nxt = bit_wdata[SXP_PAGE_SEL_POS];
            end else begin
                page_nxt = mem_wdata[SXP_PAGE_SEL_POS];
            end
        end

        // Reset last, so it beats a write
        if (srst) begin
            page_nxt = SXP_PAGE_REG_RST[SXP_PAGE_SEL_POS];
        end
    end

    always_ff @(posedge clk) begin
        page_r <= page_nxt;
    end

    // Access decode next values
    always_comb begin
        sfr_sel_nxt  = in_sfr;
        iram_sel_nxt = in_iram;
        hit_nxt      = is_page;

        bit_ok_nxt   = 1'b0;
        if (in_sfr && mem_bit_op) begin
            // only addresses ending 0x0 or 0x8
            bit_ok_nxt = bit_addr;
        end

        if (is_page) begin
            // Old page value on read-during-write
            rdata_nxt = cur_byte;
        end else begin
            // Other SFRs answer on their own paths
            rdata_nxt = 8'h00;
        end

        if (srst) begin
            sfr_sel_nxt  = 1'b0;
            iram_sel_nxt = 1'b0;
            bit_ok_nxt   = 1'b0;
            hit_nxt      = 1'b0;
            rdata_nxt    = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        sfr_sel_r  <= sfr_sel_nxt;
        iram_sel_r <= iram_sel_nxt;
        bit_ok_r   <= bit_ok_nxt;
        hit_r      <= hit_nxt;
        rdata_r    <= rdata_nxt;
    end

    // External move next values
    always_comb begin
        xen_nxt  = xmove_req;

        // Index holds between moves for the RAM port
        xidx_nxt = xidx_r;
        if (xmove_req) begin
            if (xmove_ptr16) begin
                xidx_nxt = linear_idx;
            end else begin
                xidx_nxt = paged_idx;
            end
        end

        if (srst) begin
            xen_nxt  = 1'b0;
            xidx_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        xen_r  <= xen_nxt;
        xidx_r <= xidx_nxt;
    end

    // Outputs straight from the flip-flops
    assign sfr_sel         = sfr_sel_r;
    assign iram_sel        = iram_sel_r;
    assign bit_ok          = bit_ok_r;
    assign page_reg_hit    = hit_r;
    assign sfr_rdata       = rdata_r;
    assign xram_en         = xen_r;
    assign xram_index      = xidx_r;
    assign page_select_bit = page_r;
endmodule // sxp_sfr_decode

//--- sxp_properties.sv
// Checker for SFR decode and page register
`timescale 1ns/1ps
module sxp_chk(input wire logic clk,srst,mem_req,mem_direct,mem_bit_op,
    mem_wr,xmove_req,xmove_ptr16,sfr_sel,iram_sel,bit_ok,page_reg_hit,xram_en,
    page_select_bit, input wire logic [7:0] mem_addr,mem_wdata,sfr_rdata,
    input wire logic [15:0] xmove_addr, input wire logic [8:0] xram_index);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence dsfr; mem_req && mem_direct && mem_addr[7]; endsequence
    sequence pwr; dsfr ##0 mem_wr && !mem_bit_op && mem_addr == 8'haa;
    endsequence
    sequence bwr; dsfr ##0 mem_wr && mem_bit_op && mem_addr == 8'haa;
    endsequence
    AST_SFR: assert property (dsfr |=> sfr_sel && !iram_sel)
        else $error("sfr decode");
    AST_IND: assert property (mem_req && !mem_direct |=> iram_sel)
        else $error("indirect decode");
    AST_BIT: assert property (dsfr ##0 mem_bit_op |=>
        bit_ok == ($past(mem_addr[2:0]) == 3'h0)) else $error("bit decode");
    AST_RD: assert property (page_reg_hit |->
        sfr_rdata == {7'h0, $past(page_select_bit)})
        else $error("page readback");
    AST_WR: assert property (pwr |=>
        page_select_bit == $past(mem_wdata[0])) else $error("page write");
    AST_PG: assert property (xmove_req && !xmove_ptr16 |=>
        xram_index == {$past(page_select_bit), $past(xmove_addr[7:0])})
        else $error("paged move");
    AST_P16: assert property (xmove_req && xmove_ptr16 |=>
        xram_index == $past(xmove_addr[8:0])) else $error("pointer move");
    AST_BWR: assert property (bwr |=>
        $stable(page_select_bit) && !bit_ok) else $error("bit write taken");
    AST_XEN: assert property (xmove_req |=> xram_en)
        else $error("move strobe missing");
    AST_XOFF: assert property (!xmove_req |=> !xram_en)
        else $error("move strobe spurious");
endmodule // sxp_chk
bind sxp_sfr_decode sxp_chk u_chk(.*);

//--- sxp_core.sv
// Core model issuing data and move requests
`timescale 1ns/1ps
module sxp_core(input wire logic clk, output logic mem_req,mem_direct,
    mem_bit_op,mem_wr,xmove_req,xmove_ptr16, output logic [7:0] mem_addr,
    mem_wdata, output logic [2:0] mem_bit_pos, output logic [15:0] xmove_addr);
    initial {mem_req,mem_direct,mem_bit_op,mem_wr,xmove_req,xmove_ptr16,
        mem_addr,mem_wdata,mem_bit_pos,xmove_addr} = '0;
    task acc(input logic d,b,w, input logic [7:0] ad,da);
        @(posedge clk) #1 {mem_req,mem_direct,mem_bit_op,mem_wr,mem_addr,
            mem_wdata} = {1'b1,d,b,w,ad,da};
        @(posedge clk) #1 mem_req = 0;
    endtask
    task mv(input logic p, input logic [15:0] ad);
        @(posedge clk) #1 {xmove_req,xmove_ptr16,xmove_addr} = {1'b1,p,ad};
        @(posedge clk) #1 xmove_req = 0;
    endtask
endmodule // sxp_core

//--- tb_top.sv
// Self-checking bench for SFR decode and page
`timescale 1ns/1ps
module tb_top;
    logic clk=0,srst=1,mem_req,mem_direct,mem_bit_op,mem_wr,xmove_req,
        xmove_ptr16,sfr_sel,iram_sel,bit_ok,page_reg_hit,xram_en,page_select_bit;
    logic [7:0] mem_addr,mem_wdata,sfr_rdata;
    logic [2:0] mem_bit_pos;
    logic [15:0] xmove_addr,r;
    logic [8:0] xram_index,q[$];
    logic [12:0] m[$],dec;
    assign dec = {sfr_sel,iram_sel,bit_ok,page_reg_hit,sfr_rdata,
        page_select_bit};
    int mismatches=0, check_count=0;
    always #25 clk = ~clk;
    sxp_core core(.*);
    sxp_sfr_decode DUT(.*);
    task chk(input logic [15:0] s,e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task ac(input logic d,b,w, input logic [7:0] a,da, input logic [12:0] e);
        m.push_back(e);
        core.acc(d,b,w,a,da);
    endtask
    always @(posedge clk) #2 if (xram_en === 1'b1)
        chk({7'h00,xram_index}, {7'h00,q.pop_front()});
    always @(posedge clk) #2 if (sfr_sel === 1'b1 || iram_sel === 1'b1)
        chk({3'h0,dec}, {3'h0,m.pop_front()});
    initial begin
        void'($urandom(32'h6903));
        repeat(8) @(posedge clk);
        #1 srst = 0;
        ac(1,0,1,8'haa,8'hff,{4'h9,8'h00,1'h1});
        q.push_back(9'h134);
        core.mv(0,16'h0034);
        ac(1,1,1,8'haa,8'h00,{4'h9,8'h01,1'h1});
        q.push_back(9'h1c5);
        core.mv(0,16'hffc5);
        ac(1,0,1,8'haa,8'hfe,{4'h9,8'h01,1'h0});
        q.push_back(9'h07f);
        core.mv(0,16'h017f);
        ac(1,1,0,8'h88,8'h00,{4'ha,8'h00,1'h0});
        ac(1,0,0,8'h30,8'h00,{4'h4,8'h00,1'h0});
        ac(0,0,0,8'hc0,8'h00,{4'h4,8'h00,1'h0});
        repeat(20) begin
            r = 16'($urandom);
            q.push_back(r[8:0]);
            core.mv(1,r);
        end
        ac(1,0,1,8'haa,8'h01,{4'h9,8'h00,1'h1});
        @(posedge clk) #1 srst = 1;
        @(posedge clk) #1 srst = 0;
        q.push_back(9'h055);
        core.mv(0,16'h3355);
        repeat(3) @(posedge clk);
        chk(16'(q.size() + m.size()), 16'h0000);
        give_verdict;
    end
    initial begin
        #20us mismatches++;
        give_verdict;
    end
endmodule // tb_top
